// ==== sec_regs.svh ====
// register offsets, fields, reset values and timing for the serial memory controller
`ifndef SEC_REGS_SVH
`define SEC_REGS_SVH
// ==========================================
// offsets
`define SEC_CMD_OFF 8'hB0
`define SEC_DATA_OFF 8'hB4
`define SEC_STAT_OFF 8'hB8
`define SEC_MASK_OFF 8'hBC
// ==========================================
// command register fields
`define SEC_BUSY_BIT 31
`define SEC_OP_MSB 30
`define SEC_OP_LSB 28
`define SEC_TO_BIT 9
`define SEC_LOADED_BIT 8
`define SEC_ADDR_RST 8'h00
`define SEC_DATA_RST 8'h00
// ==========================================
// status bits and timing
`define SEC_EV_DONE 0
`define SEC_EV_TO 1
`define SEC_CLK_NS 20
`define SEC_CLK_KHZ 50000
`define SEC_LINK_NS 160
`define SEC_HALF_CYC (`SEC_LINK_NS / `SEC_CLK_NS / 2)
`define SEC_TIMEOUT_MS 30
`define SEC_TIMEOUT_CYC (`SEC_TIMEOUT_MS * `SEC_CLK_KHZ)
`define SEC_SIG_RST 8'hA5
`define SEC_RELOAD_LAST 3'h6
`endif

// ==== sec_pkg.sv ====
// types shared by the serial memory controller
package sec_pkg;
  typedef enum logic [2:0] {
    SEC_OP_READ = 3'h0, SEC_OP_WR_DISABLE = 3'h1, SEC_OP_WR_ENABLE = 3'h2, SEC_OP_WRITE = 3'h3,
    SEC_OP_WRITE_ALL = 3'h4, SEC_OP_ERASE = 3'h5, SEC_OP_ERASE_ALL = 3'h6, SEC_OP_RELOAD = 3'h7
  } sec_op_t;
  typedef enum logic [4:0] {
    SEC_IDLE = 5'h01, SEC_SHIFT = 5'h02, SEC_RECV = 5'h04, SEC_GAP = 5'h08, SEC_WAIT = 5'h10
  } sec_state_t;
  // serial memory pin group
  typedef struct packed {
    logic cs;
    logic sclk;
    logic dout;
    logic dout_oe_n;
  } sec_pins_t;
endpackage

// ==== sec_ctrl.sv ====
// serial memory command controller with apb registers
// Behaviour
// - a write-location command stores the data byte at the address field location.
// - an erase-location command erases the location named by the address field.
// - with no answer within 30 ms of the start the controller abandons and goes idle.
// - a time-out sets the sticky flag in bit 9, cleared by software writing it.
// - with the data pin held high and no memory, commands finish without time-out.
// - only erase, erase-all, write and write-all can time out on a low data line.
// - read-only bit 8 shows a valid memory was found and the station address loaded.
// - the 8-bit read/write address field in bits 7-0 resets to 00h and addresses memory.
// - the data register at B4h holds in bits 7:0 the byte read or to be written.
`timescale 1ns/10ps
`include "sec_regs.svh"
module sec_ctrl import sec_pkg::*; #(
  parameter int HALF_CYC = `SEC_HALF_CYC,
  parameter int TIMEOUT_CYC = `SEC_TIMEOUT_CYC,
  parameter logic [7:0] SIGNATURE = `SEC_SIG_RST
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  output sec_pins_t pins,
  input wire logic din,
  output logic [47:0] station_addr
);
  localparam int TW = $clog2(TIMEOUT_CYC + 1);
  localparam int DW = $clog2(2 * HALF_CYC + 1);
  localparam logic [DW-1:0] DIV_LAST = DW'(2 * HALF_CYC - 1);
  localparam logic [DW-1:0] DIV_HI = DW'(HALF_CYC);
  localparam logic [TW-1:0] TO_LAST = TW'(TIMEOUT_CYC - 1);

  sec_state_t state;
  sec_op_t op;
  logic [7:0] addr, data, rx;
  logic timeout_flag, loaded, boot_pend, din_m, din_s, sig_ok, ev_done, ev_to, rx_valid;
  logic busy, start, bit_end, waits, acc, wr, rd, hit;
  logic [1:0] status, mask;
  logic [18:0] frame;
  logic [4:0] nbits, bit_cnt;
  logic [DW-1:0] div;
  logic [TW-1:0] tcnt;
  logic [2:0] ridx;
  sec_op_t start_op;
  logic [31:0] next_prdata;

  // ==========================================
  // frame building
  // start bit, two opcode bits, address, data byte for writes
  function automatic logic [18:0] build_frame(input sec_op_t o, input logic [7:0] a,
                                               input logic [7:0] d);
    case (o)
      SEC_OP_WR_DISABLE: build_frame = {3'b100, 8'h00, 8'h00};
      SEC_OP_WR_ENABLE: build_frame = {3'b100, 8'hC0, 8'h00};
      SEC_OP_WRITE: build_frame = {3'b101, a, d};
      SEC_OP_WRITE_ALL: build_frame = {3'b100, 8'h40, d};
      SEC_OP_ERASE: build_frame = {3'b111, a, 8'h00};
      SEC_OP_ERASE_ALL: build_frame = {3'b100, 8'h80, 8'h00};
      default: build_frame = {3'b110, a, 8'h00};
    endcase
  endfunction

  // ==========================================
  // apb slave
  // answers in the first access cycle, read data latched in setup
  assign pready = 1'b1;
  assign acc = psel & penable;
  assign wr = acc & pwrite;
  assign rd = acc & ~pwrite;
  assign hit = (paddr == `SEC_CMD_OFF) | (paddr == `SEC_DATA_OFF) |
               (paddr == `SEC_STAT_OFF) | (paddr == `SEC_MASK_OFF);
  assign pslverr = acc & ~hit;
  assign busy = (state != SEC_IDLE) | ev_to | ev_done; // flags settle before busy reads clear

  // read mux
  always_comb begin
    next_prdata = 32'h0000_0000;
    case (paddr)
      `SEC_CMD_OFF: begin
        next_prdata[`SEC_BUSY_BIT] = busy;
        next_prdata[`SEC_OP_MSB:`SEC_OP_LSB] = op;
        next_prdata[`SEC_TO_BIT] = timeout_flag;
        next_prdata[`SEC_LOADED_BIT] = loaded;
        next_prdata[7:0] = addr;
      end
      `SEC_DATA_OFF: next_prdata[7:0] = data;
      `SEC_STAT_OFF: next_prdata[1:0] = status;
      `SEC_MASK_OFF: next_prdata[1:0] = mask;
      default: next_prdata = 32'h0000_0000;
    endcase
  end

  // read data flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel & ~penable & ~pwrite) begin
      prdata <= next_prdata;
    end
  end

  // ==========================================
  // software registers
  // command start from software, boot reload after reset
  assign start = ~busy & (boot_pend |
                 (wr & (paddr == `SEC_CMD_OFF) & pwdata[`SEC_BUSY_BIT]));
  assign start_op = boot_pend ? SEC_OP_RELOAD : sec_op_t'(pwdata[`SEC_OP_MSB:`SEC_OP_LSB]);

  // boot reload request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      boot_pend <= 1'b1;
    end else if (~busy) begin
      boot_pend <= 1'b0;
    end
  end

  // address field, writable while idle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr <= `SEC_ADDR_RST;
    end else if (wr & (paddr == `SEC_CMD_OFF) & ~busy) begin
      addr <= pwdata[7:0];
    end
  end

  // data byte, loaded by software or by a finished read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data <= `SEC_DATA_RST;
    end else if (rx_valid) begin
      data <= rx;
    end else if (wr & (paddr == `SEC_DATA_OFF) & ~busy) begin
      data <= pwdata[7:0];
    end
  end

  // sticky time-out flag, set wins over the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timeout_flag <= 1'b0;
    end else if (ev_to) begin
      timeout_flag <= 1'b1;
    end else if (wr & (paddr == `SEC_CMD_OFF) & pwdata[`SEC_TO_BIT]) begin
      timeout_flag <= 1'b0;
    end
  end

  // ==========================================
  // interrupt
  // status cleared by read, events win
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status <= 2'h0;
      mask <= 2'h0;
    end else begin
      if (rd & (paddr == `SEC_STAT_OFF)) begin
        status <= (status & ~prdata[1:0]) | {ev_to, ev_done}; // only the bits just returned are cleared
      end else begin
        status <= status | {ev_to, ev_done};
      end
      if (wr & (paddr == `SEC_MASK_OFF)) begin
        mask <= pwdata[1:0];
      end
    end
  end

  // interrupt level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status & mask);
    end
  end

  // ==========================================
  // serial link
  // data pin synchroniser
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      din_m <= 1'b0;
      din_s <= 1'b0;
    end else begin
      din_m <= din;
      din_s <= din_m;
    end
  end

  assign bit_end = (div == DIV_LAST);
  // only these ops poll for ready and so can time out
  assign waits = (op == SEC_OP_WRITE) | (op == SEC_OP_WRITE_ALL) |
                 (op == SEC_OP_ERASE) | (op == SEC_OP_ERASE_ALL);

  // bit clock divider and command timer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div <= '0;
      tcnt <= '0;
    end else begin
      div <= (start | bit_end) ? '0 : div + 1'b1;
      tcnt <= start ? '0 : (busy ? tcnt + 1'b1 : tcnt);
    end
  end

  // command sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= SEC_IDLE;
      op <= SEC_OP_READ;
      frame <= '0;
      nbits <= 5'h00;
      bit_cnt <= 5'h00;
      rx <= 8'h00;
      ridx <= 3'h0;
      sig_ok <= 1'b0;
      loaded <= 1'b0;
      station_addr <= 48'h0;
      ev_done <= 1'b0;
      ev_to <= 1'b0;
      rx_valid <= 1'b0;
      pins <= '{cs: 1'b0, sclk: 1'b0, dout: 1'b0, dout_oe_n: 1'b1};
    end else begin
      ev_done <= 1'b0;
      ev_to <= 1'b0;
      rx_valid <= 1'b0;
      pins.dout <= frame[18];
      case (state)
        SEC_IDLE: begin
          if (start) begin
            op <= start_op;
            frame <= build_frame(start_op, start_op == SEC_OP_RELOAD ? 8'h00 : pwdata[7:0], data);
            nbits <= (start_op == SEC_OP_WRITE || start_op == SEC_OP_WRITE_ALL) ? 5'd19 : 5'd11;
            bit_cnt <= 5'h00;
            ridx <= 3'h0;
            if (start_op == SEC_OP_RELOAD) begin
              loaded <= 1'b0;
            end
            pins.cs <= 1'b1;
            pins.dout_oe_n <= 1'b0;
            state <= SEC_SHIFT;
          end
        end
        SEC_SHIFT: begin
          pins.sclk <= (div >= DIV_HI - 1'b1) & ~bit_end;
          if (bit_end) begin
            frame <= {frame[17:0], 1'b0};
            bit_cnt <= bit_cnt + 1'b1;
            if (bit_cnt == nbits - 1'b1) begin
              bit_cnt <= 5'h00;
              pins.dout_oe_n <= 1'b1;
              state <= (op == SEC_OP_READ || op == SEC_OP_RELOAD) ? SEC_RECV : SEC_GAP;
            end
          end
        end
        SEC_RECV: begin
          pins.sclk <= (div >= DIV_HI - 1'b1) & ~bit_end;
          if (bit_end) begin
            rx <= {rx[6:0], din_s};
            bit_cnt <= bit_cnt + 1'b1;
            if (bit_cnt == 5'd7) begin
              rx_valid <= (op == SEC_OP_READ);
              state <= SEC_GAP;
            end
          end
        end
        SEC_GAP: begin
          pins.cs <= 1'b0;
          pins.sclk <= 1'b0;
          if (bit_end) begin
            if (waits) begin
              pins.cs <= 1'b1;
              state <= SEC_WAIT;
            end else if (op == SEC_OP_RELOAD) begin
              // first byte is the signature, the rest the station address
              if (ridx == 3'h0) begin
                sig_ok <= (rx == SIGNATURE);
              end else begin
                station_addr <= {station_addr[39:0], rx};
              end
              if ((ridx == 3'h0 && rx != SIGNATURE) || ridx == `SEC_RELOAD_LAST) begin
                loaded <= (ridx == `SEC_RELOAD_LAST) & sig_ok;
                ev_done <= 1'b1;
                state <= SEC_IDLE;
              end else begin
                ridx <= ridx + 1'b1;
                frame <= build_frame(SEC_OP_READ, {5'h00, ridx + 1'b1}, data);
                bit_cnt <= 5'h00;
                pins.cs <= 1'b1;
                pins.dout_oe_n <= 1'b0;
                state <= SEC_SHIFT;
              end
            end else begin
              ev_done <= 1'b1;
              state <= SEC_IDLE;
            end
          end
        end
        SEC_WAIT: begin
          if (bit_end) begin
            bit_cnt <= 5'h01; // the pin is trusted only after one bit time of select
          end
          if (din_s && bit_cnt != 5'h00) begin
            pins.cs <= 1'b0;
            ev_done <= 1'b1;
            state <= SEC_IDLE;
          end else if (tcnt >= TO_LAST) begin
            pins.cs <= 1'b0;
            ev_to <= 1'b1;
            state <= SEC_IDLE;
          end
        end
        default: begin
          pins.cs <= 1'b0;
          state <= SEC_IDLE;
        end
      endcase
    end
  end

  // ==========================================
  // assertions
  to_sets_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
    ev_to |=> timeout_flag) else $error("time-out did not set flag");
  to_to_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
    ev_to |-> state == SEC_IDLE && !pins.cs) else $error("time-out left sequencer busy");
  to_bound_a: assert property (@(posedge pclk) disable iff (!presetn)
    state == SEC_WAIT |-> tcnt <= TO_LAST) else $error("wait ran past time-out");
  to_ops_only_a: assert property (@(posedge pclk) disable iff (!presetn)
    ev_to |-> waits) else $error("time-out on non write op");
  ready_ends_a: assert property (@(posedge pclk) disable iff (!presetn)
    state == SEC_WAIT && din_s && bit_cnt != 5'h00 |=> state == SEC_IDLE && ev_done && !ev_to)
    else $error("ready did not end command");
  addr_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr && paddr == `SEC_CMD_OFF && !busy |=> addr == $past(pwdata[7:0]))
    else $error("address field not written");
  data_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr && paddr == `SEC_DATA_OFF && !busy && !rx_valid |=> data == $past(pwdata[7:0]))
    else $error("data byte not written");
  write_frame_a: assert property (@(posedge pclk) disable iff (!presetn)
    start && start_op == SEC_OP_WRITE |=> frame == {3'b101, $past(pwdata[7:0]), $past(data)} && nbits == 5'd19)
    else $error("write frame wrong");
  erase_frame_a: assert property (@(posedge pclk) disable iff (!presetn)
    start && start_op == SEC_OP_ERASE |=> frame[18:8] == {3'b111, $past(pwdata[7:0])} && nbits == 5'd11)
    else $error("erase frame wrong");
  loaded_valid_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(loaded) |-> sig_ok && op == SEC_OP_RELOAD && ev_done)
    else $error("loaded without valid memory");
  write_all_wait_a: assert property (@(posedge pclk) disable iff (!presetn)
    state == SEC_GAP && bit_end && op == SEC_OP_WRITE_ALL |=> state == SEC_WAIT && pins.cs)
    else $error("write-all did not poll ready");
  cov_timeout_c: cover property (@(posedge pclk) disable iff (!presetn) ev_to);
  cov_reload_c: cover property (@(posedge pclk) disable iff (!presetn) $rose(loaded));
  cov_write_c: cover property (@(posedge pclk) disable iff (!presetn)
    state == SEC_WAIT && din_s && op == SEC_OP_WRITE);
  cov_read_c: cover property (@(posedge pclk) disable iff (!presetn) rx_valid);
endmodule

// ==== sec_mem_model.sv ====
// behavioural serial memory: write protection, busy polling and byte reads
`timescale 1ns/10ps
module sec_mem_model #(
  parameter logic [7:0] SIG = 8'h00
) (
  input wire logic pclk,
  input wire logic on,
  input wire logic [15:0] busy_len,
  input wire logic cs,
  input wire logic sclk,
  input wire logic dio,
  output logic oe,
  output logic dq
);
  logic [7:0] mem [256];
  logic [18:0] fr = '0;
  logic [4:0] n = '0;
  logic [15:0] busy = '0;
  logic wen = 1'b0; // powers up write-disabled
  logic pend = 1'b0;
  logic sk_q = 1'b0;
  logic cs_q = 1'b0;
  logic prog, era, all;
  // frame kinds: whole-array forms use op 00, erase forms set op msb or addr bit 7
  assign all = fr[17:16] == 2'b00;
  assign era = fr[17] || (all && fr[15]);
  assign prog = (fr[17:16] != 2'b10) && !(all && fr[15] == fr[14]);
  // contents start erased apart from the signature and station bytes
  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = (i == 0) ? SIG : (i < 7) ? 8'(8'h10 + i) : 8'hFF;
    end
    oe = 1'b0;
    dq = 1'b1;
  end
  // ==========================================
  // shift in on sclk rise, out on sclk fall, act when the frame ends
  always @(posedge pclk) begin
    sk_q <= sclk;
    cs_q <= cs;
    if (busy != 16'h0000)
      busy <= busy - 16'h0001;
    if (on && cs && sclk && !sk_q && n < 5'd19) begin
      fr[5'd18 - n] <= dio;
      n <= n + 5'd1;
    end
    if (cs && !sclk && sk_q) begin
      oe <= fr[17:16] == 2'b10 && n >= 5'd11 && n < 5'd19; // read data msb first
      dq <= mem[fr[15:8]][3'(5'd18 - n)];
    end
    if (cs && n == 5'd0 && pend) begin
      oe <= 1'b1;
      dq <= busy == 16'h0000; // low while programming
    end
    if (!cs && cs_q) begin
      oe <= 1'b0;
      n <= 5'd0;
      pend <= n >= 5'd11 && prog;
      if (n >= 5'd11 && all && fr[15] == fr[14])
        wen <= fr[15]; // enable and disable frames
      if (n >= 5'd11 && prog && wen) begin
        busy <= busy_len;
        for (int i = 0; i < 256; i++) begin
          if (all || i == fr[15:8]) mem[i] <= era ? 8'hFF : fr[7:0];
        end
      end
    end
  end
endmodule

// ==== sec_ctrl_tb.sv ====
// self-checking bench for the serial memory controller
`timescale 1ns/10ps
`include "sec_regs.svh"
module sec_ctrl_tb import sec_pkg::*;;
  localparam int TO = 2000;
  localparam logic [7:0] CR = `SEC_CMD_OFF;
  localparam logic [7:0] DR = `SEC_DATA_OFF;
  localparam logic [7:0] SR = `SEC_STAT_OFF;
  localparam logic [7:0] MR = `SEC_MASK_OFF;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, din;
  logic pull_hi, mem_on, mem_oe, mem_dq, erv, texp;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdv;
  logic [47:0] station_addr;
  logic [15:0] busy_len;
  sec_pins_t pins;
  int mismatches, tests_run, el;
  // ==========================================
  // clock, data pin resolution and instances
  always #10 pclk = ~pclk;
  assign din = !pins.dout_oe_n ? pins.dout : (mem_on && mem_oe) ? mem_dq : pull_hi;
  sec_ctrl #(.TIMEOUT_CYC(TO)) uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .pins(pins), .din(din), .station_addr(station_addr));
  sec_mem_model #(.SIG(`SEC_SIG_RST)) mem (.pclk(pclk), .on(mem_on), .busy_len(busy_len),
    .cs(pins.cs), .sclk(pins.sclk), .dio(din), .oe(mem_oe), .dq(mem_dq));
  // ==========================================
  // compare, verdict and bus tasks
  task automatic chk(input string what, input logic [47:0] seen, input logic [47:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rdv = prdata;
    erv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 20) begin
      mismatches++;
      tally_and_finish();
    end
  endtask
  // poll busy until clear, bounded
  task automatic idle();
    int k;
    k = 0;
    do begin
      apb(1'b0, CR, 32'h0);
      k++;
    end while (rdv[31] !== 1'b0 && k < 1500);
    if (k >= 1500) begin
      mismatches++;
      tally_and_finish();
    end
  endtask
  task automatic cmd(input sec_op_t op, input logic [7:0] a);
    realtime t0;
    apb(1'b1, CR, {1'b1, op, 20'h0, a});
    t0 = $realtime;
    idle();
    el = int'(($realtime - t0) / 20.0);
  endtask
  task automatic rd_loc(input logic [7:0] a, input logic [31:0] exp, input string what);
    cmd(SEC_OP_READ, a);
    apb(1'b0, DR, 32'h0);
    chk(what, rdv, exp);
  endtask
  // ==========================================
  // main sequence
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    mem_on = 1'b1;
    pull_hi = 1'b1;
    busy_len = 16'd40;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    // boot load and reset values
    idle();
    chk("loaded", rdv[8], 1'b1);
    chk("addr reset", rdv[7:0], 8'h00);
    chk("station", station_addr, 48'h111213141516);
    apb(1'b0, DR, 32'h0);
    chk("data reset", rdv, 32'h0);
    apb(1'b0, SR, 32'h0);
    apb(1'b1, DR, 32'hFFFFFFFF);
    apb(1'b0, DR, 32'h0);
    chk("data width", rdv, 32'hFF);
    // write ignored before any enable
    apb(1'b1, DR, 32'h3C);
    cmd(SEC_OP_WRITE, 8'h10);
    rd_loc(8'h10, 32'hFF, "powerup protect");
    // enable, then write with the done interrupt unmasked
    cmd(SEC_OP_WR_ENABLE, 8'h00);
    apb(1'b1, DR, 32'h3C);
    apb(1'b1, MR, 32'h1);
    cmd(SEC_OP_WRITE, 8'h10);
    chk("addr field", rdv[7:0], 8'h10);
    chk("irq done", irq, 1'b1);
    apb(1'b0, SR, 32'h0);
    chk("done status", rdv[1:0], 2'b01);
    repeat (3) @(posedge pclk);
    chk("irq cleared", irq, 1'b0);
    apb(1'b1, MR, 32'h0);
    rd_loc(8'h10, 32'h3C, "write loc");
    cmd(SEC_OP_ERASE, 8'h10);
    rd_loc(8'h10, 32'hFF, "erase loc");
    // slow memory for whole-array commands, then reloads
    busy_len <= 16'd400;
    apb(1'b1, DR, 32'h5A);
    cmd(SEC_OP_WRITE_ALL, 8'h00);
    chk("write all poll", el > 400, 1'b1);
    rd_loc(8'hFF, 32'h5A, "write all");
    cmd(SEC_OP_ERASE_ALL, 8'h00);
    rd_loc(8'h07, 32'hFF, "erase all");
    cmd(SEC_OP_RELOAD, 8'h00);
    chk("no signature", rdv[8], 1'b0);
    apb(1'b1, DR, {24'h0, `SEC_SIG_RST});
    cmd(SEC_OP_WRITE, 8'h00);
    cmd(SEC_OP_RELOAD, 8'h00);
    chk("reloaded", rdv[8], 1'b1);
    chk("station erased", station_addr, 48'hFFFFFFFFFFFF);
    // disable blocks later writes
    cmd(SEC_OP_WR_DISABLE, 8'h00);
    apb(1'b1, DR, 32'h77);
    cmd(SEC_OP_WRITE, 8'h20);
    rd_loc(8'h20, 32'hFF, "disabled");
    // no memory fitted: every command with the pin pulled high, then low
    mem_on <= 1'b0;
    apb(1'b1, MR, 32'h2);
    for (int p = 1; p >= 0; p--) begin
      pull_hi <= p[0];
      for (int i = 0; i < 8; i++) begin
        texp = p == 0 && i >= 3 && i <= 6;
        cmd(sec_op_t'(i), 8'h05);
        chk("time-out flag", rdv[9], texp);
        chk("irq time-out", irq, texp);
        if (texp) begin
          chk("abandon time", el >= TO && el < TO + 10, 1'b1);
          apb(1'b1, CR, 32'h200);
          apb(1'b0, CR, 32'h0);
          chk("flag clear", rdv[9], 1'b0);
          apb(1'b0, SR, 32'h0);
        end
      end
    end
    // unmapped address is refused
    apb(1'b0, 8'hC0, 32'h0);
    chk("unmapped err", erv, 1'b1);
    chk("unmapped data", rdv, 32'h0);
    tally_and_finish();
  end
endmodule
